/* bench/ca_odt_vref_control_tb.sv */
// self-checking bench for the termination decode and reference step control
// assumes the controller model drives the link; the bond pad is driven here
`timescale 1ns/1ns
module ca_odt_vref_control_tb;
   import ca_odt_vref_pkg::*;
   localparam int unsigned WEAK = 20;
   logic        refClk;
   logic        sysRst;
   logic        bondPad;
   link_pins_s  linkPins;
   term_out_s   termOut;
   logic        vrefRange;
   logic [5:0]  vrefCode;
   logic        vrefSettling;
   int          errors;
   int          nTests;
   int          curCode;
   int          curRange;
   int          prevOp;
   int          boost;
   logic [7:0]  ops [$] = {8'h01, 8'h02, 8'h02, 8'h07, 8'h06, 8'h46, 8'h00};

   ca_odt_vref_control #(.WeakCycles(WEAK)) i_ca_odt_vref_control (
      .ref_clk              (refClk),
      .sys_rst              (sysRst),
      .linkIn               (linkPins),
      .multirankTermBondPad (bondPad),
      .termOut              (termOut),
      .vrefRange            (vrefRange),
      .vrefCode             (vrefCode),
      .vrefSettling         (vrefSettling)
   );
   ctrl_link_model i_ctrl_link_model (.ref_clk(refClk), .linkOut(linkPins));

   always #20 refClk = ~refClk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report;
      if (errors == 0 && nTests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report

   task automatic term_case(input logic [2:0] fld, input logic pad, input logic [7:0] ext);
      logic [7:0] ohms [8] = '{8'h00, 8'hF0, 8'h78, 8'h50, 8'h3C, 8'h30, 8'h28, 8'h00};
      logic       en;
      en = (fld != 3'h0) && (fld != 3'h7);
      i_ctrl_link_model.mode_register_write(TERM_EXT_ADDR, ext);
      i_ctrl_link_model.mode_register_write(TERM_CFG_ADDR, {ext[7], fld, ext[3:0]});
      i_ctrl_link_model.mode_register_write(6'h3F, 8'h00);
      @(posedge refClk) #2;
      bondPad = pad;
      repeat (10) @(posedge refClk);
      #2;
      check(32'(termOut.caOn), 32'(en & pad & ~ext[CA_TERM_DIS_BIT]));
      check(32'(termOut.ckOn), 32'(en & (pad | ext[CK_TERM_EN_BIT])));
      check(32'(termOut.csOn), 32'(en & (pad | ext[CS_TERM_EN_BIT])));
      check(32'({termOut.caCode, termOut.caOhms}), 32'({fld, ohms[fld]}));
   endtask : term_case

   task automatic vref_case(input logic [7:0] op);
      int lim;
      int d;
      int n;
      d = int'(op[5:0]) - curCode;
      if (int'(op) == prevOp) lim = 0;
      else if (boost == 0) lim = WEAK;
      else if (int'(op[6]) != curRange) lim = 6;
      else if (d == 1 || d == -1) lim = 2;
      else lim = 5;
      fork
         i_ctrl_link_model.mode_register_write(DQ_REF_ADDR, op);
         begin
            for (n = 0; n < 100 && vrefSettling !== 1'b1; n++) @(posedge refClk) #1;
            for (n = 0; n < 2 * WEAK && vrefSettling === 1'b1; n++) @(posedge refClk) #1;
         end
      join
      check(32'(n), 32'(lim));
      check(32'({vrefRange, vrefCode}), 32'(op[6:0]));
      prevOp   = int'(op);
      curCode  = int'(op[5:0]);
      curRange = int'(op[6]);
   endtask : vref_case

   initial begin
      refClk = 1'b0;
      sysRst = 1'b1;
      bondPad = 1'b0;
      {errors, nTests, curCode, curRange, prevOp, boost} = '0;
      void'($urandom(79282));
      repeat (10) @(posedge refClk);
      #2 sysRst = 1'b0;
      @(posedge refClk) #2;
      check(32'({termOut, vrefRange, vrefCode, vrefSettling}), 32'h0);
      for (int i = 0; i < 16; i++) term_case(3'(i), i[3], 8'($urandom));
      for (int i = 0; i < 11; i++) begin
         if (i == 1) begin
            i_ctrl_link_model.mode_register_write(REF_CUR_ADDR, 8'h08);
            boost = 1;
         end
         vref_case(i < 7 ? ops[i] : 8'($urandom & 32'h7F));
      end
      // mid-run reset with termination on: it must drop and stay off until reprogrammed
      i_ctrl_link_model.mode_register_write(TERM_CFG_ADDR, 8'h10);
      repeat (3) @(posedge refClk);
      #2;
      check(32'(termOut.ckOn), 32'h1);
      sysRst = 1'b1;
      repeat (3) @(posedge refClk);
      #2 sysRst = 1'b0;
      @(posedge refClk) #2;
      check(32'({termOut, vrefRange, vrefCode, vrefSettling}), 32'h0);
      repeat (10) @(posedge refClk);
      #2;
      check(32'({termOut.caOn, termOut.ckOn, termOut.csOn}), 32'h0);
      final_report;
   end

   // whole run is well under 20000 cycles
   initial begin
      #1_000_000;
      errors++;
      final_report;
   end
endmodule : ca_odt_vref_control_tb

/* bench/ctrl_mrw_model.sv */
// far-side model: a memory controller issuing mode register writes on the link
// assumes the bench drives the write task from one process at a time
`timescale 1ns/1ns
module ctrl_link_model
   import ca_odt_vref_pkg::*;
(
   // core clock used only to place edges
   input  wire logic       ref_clk,
   // link towards the device
   output      link_pins_s linkOut
);
   initial begin
      linkOut = '0;
   end

   // single rank on this link, so the terminating rank is trained first
   // one pull-up point, valid for every termination value, is kept for good:
   // no recalibration is ever owed and no do-not-use pairing can arise
   // ck stands still between frames; fields held a full ck period around the rise
   task automatic mode_register_write(input logic [5:0] addr, input logic [7:0] op);
      @(posedge ref_clk) #2;
      linkOut.modeRegisterWriteCmd = 1'b1;
      linkOut.addr                 = addr;
      linkOut.op                   = op;
      #160;
      linkOut.ck = 1'b1;
      #160;
      linkOut.ck = 1'b0;
      #160;
      // released fields must not keep showing the old value
      linkOut.modeRegisterWriteCmd = 1'b0;
      linkOut.addr                 = ~addr;
      linkOut.op                   = ~op;
   endtask : mode_register_write
endmodule : ctrl_link_model

/* design/ca_odt_vref_control.sv */
// command/address termination decode and data reference-voltage step control
// assumes link pins (clock, command, bond pad) are asynchronous to ref_clk
// and that the controller keeps its own calibration and training ordering
`timescale 1ns/1ns
module ca_odt_vref_control #(
   parameter int unsigned WeakCycles = ca_odt_vref_pkg::VREF_WEAK_CYC
) (
   // clock and reset
   input  wire logic                         ref_clk,
   input  wire logic                         sys_rst,
   // link from the controller and strap pad
   input  wire ca_odt_vref_pkg::link_pins_s  linkIn,
   input  wire logic                         multirankTermBondPad,
   // termination enables
   output      ca_odt_vref_pkg::term_out_s   termOut,
   // reference voltage
   output      logic                         vrefRange,
   output      logic [5:0]                   vrefCode,
   output      logic                         vrefSettling
);
   import ca_odt_vref_pkg::*;

   typedef struct packed {
      link_pins_s  s1;
      link_pins_s  s2;
      link_pins_s  s3;
      logic [2:0]  padSync;
      logic        ckLvl;
      logic        bond;
      logic [7:0]  termCfg;
      logic [7:0]  refCur;
      logic [7:0]  dqRef;
      logic [7:0]  termExt;
      vref_state_e fsm;
      logic [14:0] timer;
      logic [14:0] limit;
      term_out_s   term;
      logic        vRange;
      logic [5:0]  vCode;
      logic        settling;
   } state_s;

   state_s st_ff;
   state_s nxt_st;

   // ohms for each field value; 0 and 7 give 0 meaning no termination
   function automatic logic [7:0] field_ohms(input logic [2:0] f);
      unique case (f)
         3'h1:    field_ohms = 8'hF0;
         3'h2:    field_ohms = 8'h78;
         3'h3:    field_ohms = 8'h50;
         3'h4:    field_ohms = 8'h3C;
         3'h5:    field_ohms = 8'h30;
         3'h6:    field_ohms = 8'h28;
         default: field_ohms = 8'h00;
      endcase
   endfunction : field_ohms

   logic              ckRise;
   logic              take;
   logic              startVref;
   logic signed [6:0] delta;
   logic [2:0]        caField;
   logic              caEnabled;
   logic [14:0]       limitSel;
   logic [14:0]       timerInc;

   always_comb begin
      nxt_st = st_ff;
      // three-stage synchronisers; stage one feeds stage two only
      nxt_st.s1 = linkIn;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      nxt_st.padSync = {st_ff.padSync[1:0], multirankTermBondPad};
      if (st_ff.s2.ck == st_ff.s3.ck) begin
         nxt_st.ckLvl = st_ff.s3.ck;
      end
      if (st_ff.padSync[1] == st_ff.padSync[2]) begin
         nxt_st.bond = st_ff.padSync[2];
      end
      ckRise = (st_ff.s2.ck == st_ff.s3.ck) && st_ff.s3.ck && !st_ff.ckLvl;
      take = ckRise && st_ff.s3.modeRegisterWriteCmd;
      startVref = 1'b0;
      if (take) begin
         unique case (st_ff.s3.addr)
            TERM_CFG_ADDR: nxt_st.termCfg = st_ff.s3.op;
            REF_CUR_ADDR:  nxt_st.refCur  = st_ff.s3.op;
            TERM_EXT_ADDR: nxt_st.termExt = st_ff.s3.op;
            DQ_REF_ADDR: begin
               nxt_st.dqRef = st_ff.s3.op;
               startVref = (st_ff.s3.op != st_ff.dqRef);
            end
            default: ;
         endcase
      end
      // signed step count from the applied code
      delta = 7'(signed'({1'b0, st_ff.s3.op[DQ_CODE_MSB:0]}))
            - 7'(signed'({1'b0, st_ff.vCode}));
      if (!st_ff.refCur[BOOST_BIT]) begin
         limitSel = 15'(WeakCycles);
      end else if (st_ff.s3.op[DQ_RANGE_BIT] != st_ff.vRange) begin
         limitSel = VREF_LONG_CYC;
      end else if (delta == 7'sd1 || delta == -7'sd1) begin
         limitSel = VREF_SHORT_CYC;
      end else begin
         limitSel = VREF_MIDDLE_CYC;
      end
      timerInc = st_ff.timer + 15'h0001;
      unique case (st_ff.fsm)
         VREF_IDLE: ;
         VREF_SETTLE: begin
            nxt_st.timer = timerInc;
            if (timerInc >= st_ff.limit) begin
               nxt_st.vRange = st_ff.dqRef[DQ_RANGE_BIT];
               nxt_st.vCode = st_ff.dqRef[DQ_CODE_MSB:0];
               nxt_st.settling = 1'b0;
               nxt_st.fsm = VREF_IDLE;
            end
         end
      endcase
      // a new write mid-settle restarts from the value applied so far
      if (startVref) begin
         nxt_st.fsm = VREF_SETTLE;
         nxt_st.timer = 15'h0000;
         nxt_st.limit = limitSel;
         nxt_st.settling = 1'b1;
      end
      // no power state input: termination holds through power-down
      // ohm changes take effect at once, no calibration step
      caField = st_ff.termCfg[CA_TERM_MSB:CA_TERM_LSB];
      caEnabled = (caField != CA_TERM_OFF) && (caField <= CA_TERM_MAX);
      nxt_st.term.caCode = caField;
      nxt_st.term.caOhms = field_ohms(caField);
      if (!caEnabled) begin
         nxt_st.term.caOn = 1'b0;
         nxt_st.term.ckOn = 1'b0;
         nxt_st.term.csOn = 1'b0;
      end else if (st_ff.bond) begin
         nxt_st.term.caOn = !st_ff.termExt[CA_TERM_DIS_BIT];
         nxt_st.term.ckOn = 1'b1;
         nxt_st.term.csOn = 1'b1;
      end else begin
         nxt_st.term.caOn = 1'b0;
         nxt_st.term.ckOn = st_ff.termExt[CK_TERM_EN_BIT];
         nxt_st.term.csOn = st_ff.termExt[CS_TERM_EN_BIT];
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff <= '{s1: '0, s2: '0, s3: '0, padSync: 3'h0, ckLvl: 1'b0, bond: 1'b0,
                    termCfg: TERM_CFG_RST, refCur: REF_CUR_RST, dqRef: DQ_REF_RST,
                    termExt: TERM_EXT_RST, fsm: VREF_IDLE, timer: 15'h0000,
                    limit: 15'h0000, term: '0, vRange: 1'b0, vCode: 6'h00,
                    settling: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign termOut = st_ff.term;
   assign vrefRange = st_ff.vRange;
   assign vrefCode = st_ff.vCode;
   assign vrefSettling = st_ff.settling;

   logic [2:0] fieldNow;
   assign fieldNow = st_ff.termCfg[CA_TERM_MSB:CA_TERM_LSB];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   chk_field_off_all: assert property ((fieldNow == CA_TERM_OFF) |=>
      (!termOut.caOn && !termOut.ckOn && !termOut.csOn))
      else $error("termination on while field disabled");
   chk_pad_low_ca: assert property (!st_ff.bond |=> !termOut.caOn)
      else $error("address terminated with bond pad low");
   chk_pad_high_on: assert property ((st_ff.bond && fieldNow != CA_TERM_OFF &&
      fieldNow <= CA_TERM_MAX) |=> (termOut.ckOn && termOut.csOn &&
      termOut.caOn == !$past(st_ff.termExt[CA_TERM_DIS_BIT])))
      else $error("pad high termination mismatch");
   chk_pad_low_ext: assert property ((!st_ff.bond && fieldNow != CA_TERM_OFF &&
      fieldNow <= CA_TERM_MAX) |=> (termOut.ckOn == $past(st_ff.termExt[CK_TERM_EN_BIT])
      && termOut.csOn == $past(st_ff.termExt[CS_TERM_EN_BIT])))
      else $error("pad low clock or select mismatch");
   chk_ohms_decode: assert property ((fieldNow == 3'h4) |=> termOut.caOhms == 8'h3C)
      else $error("ohm decode wrong");
   chk_range_apply: assert property ($fell(vrefSettling) |->
      (vrefRange == st_ff.dqRef[DQ_RANGE_BIT] && vrefCode == st_ff.dqRef[DQ_CODE_MSB:0]))
      else $error("reference not applied at end of settle");
   chk_short_bound: assert property (($rose(vrefSettling) && st_ff.limit == VREF_SHORT_CYC)
      |-> ##[1:2] (!vrefSettling || st_ff.timer == 15'h0000))
      else $error("single step settle too long");
   chk_weak_limit: assert property ((startVref && !st_ff.refCur[BOOST_BIT])
      |=> st_ff.limit == 15'(WeakCycles))
      else $error("weak current limit not chosen");
   chk_timer_bound: assert property ((st_ff.fsm == VREF_SETTLE) |->
      (st_ff.timer < st_ff.limit))
      else $error("settle timer overran its limit");

   cov_pad_high_on: cover property (st_ff.bond ##1 termOut.caOn);
   cov_pad_low_cs: cover property (!st_ff.bond ##1 termOut.csOn);
   cov_vref_short: cover property (startVref && limitSel == VREF_SHORT_CYC);
   cov_vref_range: cover property (startVref && limitSel == VREF_LONG_CYC);
endmodule : ca_odt_vref_control

/* design/ca_odt_vref_pkg.sv */
// constants, encodings and carriers for the termination / reference control block
// assumes a single 25 MHz core clock; link pins arrive unsynchronised
package ca_odt_vref_pkg;
   // core clock
   localparam int unsigned CLK_MHZ = 25;
   // mode register addresses
   localparam logic [5:0] TERM_CFG_ADDR   = 6'h0B;
   localparam logic [5:0] REF_CUR_ADDR    = 6'h0D;
   localparam logic [5:0] DQ_REF_ADDR     = 6'h0E;
   localparam logic [5:0] TERM_EXT_ADDR   = 6'h16;
   // field positions
   localparam int unsigned CA_TERM_LSB     = 4;
   localparam int unsigned CA_TERM_MSB     = 6;
   localparam int unsigned DQ_RANGE_BIT    = 6;
   localparam int unsigned DQ_CODE_MSB     = 5;
   localparam int unsigned BOOST_BIT       = 3;
   localparam int unsigned CK_TERM_EN_BIT  = 3;
   localparam int unsigned CS_TERM_EN_BIT  = 4;
   localparam int unsigned CA_TERM_DIS_BIT = 5;
   // reset values and termination field limits
   localparam logic [7:0] TERM_CFG_RST = 8'h00;
   localparam logic [7:0] REF_CUR_RST  = 8'h00;
   localparam logic [7:0] DQ_REF_RST   = 8'h00;
   localparam logic [7:0] TERM_EXT_RST = 8'h00;
   localparam logic [2:0] CA_TERM_OFF  = 3'h0;
   localparam logic [2:0] CA_TERM_MAX  = 3'h6;
   // reference settle times, longest allowed, rounded down to cycles
   localparam int unsigned VREF_SHORT_NS  = 100;
   localparam int unsigned VREF_MIDDLE_NS = 200;
   localparam int unsigned VREF_LONG_NS   = 250;
   localparam int unsigned VREF_WEAK_MS   = 1;
   localparam logic [14:0] VREF_SHORT_CYC  = 15'(VREF_SHORT_NS * CLK_MHZ / 1000);
   localparam logic [14:0] VREF_MIDDLE_CYC = 15'(VREF_MIDDLE_NS * CLK_MHZ / 1000);
   localparam logic [14:0] VREF_LONG_CYC   = 15'(VREF_LONG_NS * CLK_MHZ / 1000);
   localparam int unsigned VREF_WEAK_CYC   = VREF_WEAK_MS * 1000 * CLK_MHZ;

   typedef enum logic [1:0] {
      VREF_IDLE   = 2'b01,
      VREF_SETTLE = 2'b10
   } vref_state_e;

   // mode register write command as seen on the link
   typedef struct packed {
      logic       ck;
      logic       modeRegisterWriteCmd;
      logic [5:0] addr;
      logic [7:0] op;
   } link_pins_s;

   // termination enables presented to the pad ring
   typedef struct packed {
      logic       caOn;
      logic       ckOn;
      logic       csOn;
      logic [2:0] caCode;
      logic [7:0] caOhms;
   } term_out_s;
endpackage : ca_odt_vref_pkg
